// file: monitor_config_and_status_regs.sv
// Purpose: configuration and interrupt status registers of the monitor
// Assumes: Avalon-MM slave with waitrequest, power-on reset on rst_n
// Notes: measurement and fan loops sit outside and use these outputs
//
// Overview of operation
// - run bit set uses programmed limits
// - run bit clear selects default limits
// - clearing run never touches limit registers
// - run bit read-only after lock written
// - lock freezes lockable bits until power cycle
// - writes to locked registers are discarded
// - ready flag set once powered up
// - full-speed bit forces fans, resets zero
// - full-speed bit stays writable when locked
// - bypass bit skips tach spin-up detection
// - timeout bit enables bus timeout, lockable
// - supply-scale bit picks 5 V or 3.3 V
// - bits 0-3 flag voltage channel limits
// - read clears flag only if condition gone
// - overtemp mode: bit 3 flags timer overrun
// - bits 4-6 flag temperature channel limits
// - bit 7 is OR of second status
// - both status registers reset to zero

`timescale 1ns/1ps

module monitor_config_and_status_regs
    import monitor_regs_pkg::*;
#(
    parameter int TICK_CYCLES = OVT_TICK_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // measurement side
    input wire logic powered_up,
    input wire logic [NUM_FLAGS1-1:0] limit_fault,
    input wire logic [7:0] secondary_fault,
    input wire logic overtemp_mode,
    input wire logic overtemp_pin_n,
    input wire logic [OVT_CNT_W-1:0] overtemp_time_limit,
    // configuration outputs and secondary status summary
    output logic monitor_run,
    output logic limits_locked,
    output logic fans_forced_max,
    output logic core_power_report,
    output logic spin_up_pulse_bypass,
    output logic bus_timeout_select,
    output logic supply_is_5v,
    output logic any_secondary_flag
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic pin_meta;
        logic pin_sync;
        logic [31:0] tick_cnt;
        logic [OVT_CNT_W-1:0] ovt_time;
        logic ovt_over;
        logic [7:0] cfg;
        logic [NUM_FLAGS1-1:0] stat1;
        logic [7:0] stat2;
        logic wait_n;
        logic wait_req;
        logic sec_any;
        logic [7:0] rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic req;
    logic commit;
    logic hit_cfg;
    logic hit_st1;
    logic hit_st2;
    logic [NUM_FLAGS1-1:0] cond1;
    logic [NUM_FLAGS1-1:0] clr1;
    logic [7:0] clr2;
    logic [7:0] cfg_view;
    logic [7:0] st1_view;
    logic tick;

    assign req = avs_read | avs_write;
    assign commit = req & st_r.wait_n;
    assign hit_cfg = avs_address[ADDR_W-1:2] == IDX_CONFIG;
    assign hit_st1 = avs_address[ADDR_W-1:2] == IDX_STATUS1;
    assign hit_st2 = avs_address[ADDR_W-1:2] == IDX_STATUS2;
    assign tick = st_r.tick_cnt == 32'(TICK_CYCLES - 1);

    // ------------------------------------------------------------
    // views of readable registers
    // ------------------------------------------------------------
    always_comb begin
        cfg_view = st_r.cfg;
        cfg_view[CFG_READY] = powered_up;
        st1_view = {|st_r.stat2, st_r.stat1};
    end

    // ------------------------------------------------------------
    // fault conditions
    // ------------------------------------------------------------
    always_comb begin
        cond1 = limit_fault;
        if (overtemp_mode) begin
            cond1[ST_V5_TIMER] = st_r.ovt_over;
        end
        // clear only bits read as one and now gone
        clr1 = {NUM_FLAGS1{commit & avs_read & hit_st1}}
            & st_r.rdata[NUM_FLAGS1-1:0] & ~cond1;
        clr2 = {8{commit & avs_read & hit_st2}} & st_r.rdata
            & ~secondary_fault;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_meta = ~overtemp_pin_n;
        st_nxt.pin_sync = st_r.pin_meta;

        // tick divider and continuous assertion timer
        st_nxt.tick_cnt = tick ? 32'h0 : st_r.tick_cnt + 32'h1;
        if (!st_r.pin_sync) begin
            st_nxt.ovt_time = '0;
            st_nxt.ovt_over = 1'b0;
        end else if (tick) begin
            if (st_r.ovt_time != {OVT_CNT_W{1'b1}}) begin
                st_nxt.ovt_time = st_r.ovt_time + 1'b1;
            end
            st_nxt.ovt_over = st_r.ovt_time > overtemp_time_limit;
        end

        st_nxt.stat1 = (st_r.stat1 & ~clr1) | cond1;
        st_nxt.stat2 = (st_r.stat2 & ~clr2) | secondary_fault;
        // summary kept in its own flop
        st_nxt.sec_any = |st_nxt.stat2;

        // bus handshake: one wait cycle, then answer
        if (req && !st_r.wait_n) begin
            st_nxt.wait_n = 1'b1;
            unique case (1'b1)
                hit_cfg: st_nxt.rdata = cfg_view;
                hit_st1: st_nxt.rdata = st1_view;
                hit_st2: st_nxt.rdata = st_r.stat2;
                default: st_nxt.rdata = 8'h00;
            endcase
        end else if (commit) begin
            st_nxt.wait_n = 1'b0;
        end
        st_nxt.wait_req = ~st_nxt.wait_n;

        if (commit && avs_write && hit_cfg && avs_byteenable[0]) begin
            if (!st_r.cfg[CFG_LOCK]) begin
                st_nxt.cfg[CFG_RUN] = avs_writedata[CFG_RUN];
                st_nxt.cfg[CFG_LOCK] = avs_writedata[CFG_LOCK];
                st_nxt.cfg[CFG_POWER_REPORT] =
                    avs_writedata[CFG_POWER_REPORT];
                st_nxt.cfg[CFG_BUS_TIMEOUT] =
                    avs_writedata[CFG_BUS_TIMEOUT];
                st_nxt.cfg[CFG_SUPPLY_5V] = avs_writedata[CFG_SUPPLY_5V];
            end
            st_nxt.cfg[CFG_FANS_MAX] = avs_writedata[CFG_FANS_MAX];
            st_nxt.cfg[CFG_SPIN_BYPASS] = avs_writedata[CFG_SPIN_BYPASS];
        end
        st_nxt.cfg[CFG_READY] = 1'b0;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r.pin_meta <= 1'b0;
            st_r.pin_sync <= 1'b0;
            st_r.tick_cnt <= 32'h0;
            st_r.ovt_time <= '0;
            st_r.ovt_over <= 1'b0;
            st_r.cfg <= CONFIG_RESET;
            st_r.stat1 <= STATUS1_RESET[NUM_FLAGS1-1:0];
            st_r.stat2 <= STATUS2_RESET;
            st_r.wait_n <= 1'b0;
            st_r.wait_req <= 1'b1;
            st_r.sec_any <= 1'b0;
            st_r.rdata <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign avs_readdata = {24'h0, st_r.rdata};
    assign avs_waitrequest = st_r.wait_req;
    assign monitor_run = st_r.cfg[CFG_RUN];
    assign limits_locked = st_r.cfg[CFG_LOCK];
    assign fans_forced_max = st_r.cfg[CFG_FANS_MAX];
    assign core_power_report = st_r.cfg[CFG_POWER_REPORT];
    assign spin_up_pulse_bypass = st_r.cfg[CFG_SPIN_BYPASS];
    assign bus_timeout_select = st_r.cfg[CFG_BUS_TIMEOUT];
    assign supply_is_5v = st_r.cfg[CFG_SUPPLY_5V];
    assign any_secondary_flag = st_r.sec_any;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    logic cfg_wr;
    assign cfg_wr = commit & avs_write & hit_cfg & avs_byteenable[0];

    lock_sticky_a:
    assert property (limits_locked |=> limits_locked)
        else $error("lock bit dropped");

    run_frozen_a:
    assert property (cfg_wr && limits_locked |=> $stable(monitor_run))
        else $error("run bit changed while locked");

    locked_bits_a:
    assert property (cfg_wr && limits_locked
        |=> $stable(st_r.cfg & CFG_LOCKABLE_MASK))
        else $error("lockable bit changed while locked");

    fans_write_a:
    assert property (cfg_wr
        |=> fans_forced_max == $past(avs_writedata[CFG_FANS_MAX]))
        else $error("full-speed write lost");

    run_write_a:
    assert property (cfg_wr && !limits_locked
        |=> monitor_run == $past(avs_writedata[CFG_RUN]))
        else $error("run write lost while unlocked");

    flag_latch_a:
    assert property (limit_fault[ST_REMOTE1]
        |=> st_r.stat1[ST_REMOTE1] [*1])
        else $error("temperature flag not latched");

    flag_keep_a:
    assert property (st_r.stat1[ST_CORE] && limit_fault[ST_CORE]
        |=> st_r.stat1[ST_CORE])
        else $error("flag cleared while fault persists");

    flag_clear_a:
    assert property (commit && avs_read && hit_st1
        && st_r.rdata[ST_V2P5] && !limit_fault[ST_V2P5]
        |=> !st_r.stat1[ST_V2P5])
        else $error("flag not cleared by read");

    summary_read_a:
    assert property (req && avs_waitrequest && hit_st1
        |=> avs_readdata[ST_ANY_SECONDARY] == $past(|st_r.stat2))
        else $error("summary bit wrong");

    ready_read_a:
    assert property (req && avs_waitrequest && hit_cfg && powered_up
        |=> avs_readdata[CFG_READY])
        else $error("ready flag not shown");

    timer_flag_a:
    assert property (overtemp_mode && st_r.ovt_over
        |=> st_r.stat1[ST_V5_TIMER])
        else $error("timer overrun not flagged");

    answer_once_a:
    assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held for more than one cycle");

    answer_time_a:
    assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered in one cycle");

    bypass_write_a:
    assert property (cfg_wr
        |=> spin_up_pulse_bypass == $past(avs_writedata[CFG_SPIN_BYPASS]))
        else $error("bypass write lost");

    timeout_write_a:
    assert property (cfg_wr && !limits_locked
        |=> bus_timeout_select == $past(avs_writedata[CFG_BUS_TIMEOUT]))
        else $error("timeout select write lost");

    supply_write_a:
    assert property (cfg_wr && !limits_locked
        |=> supply_is_5v == $past(avs_writedata[CFG_SUPPLY_5V]))
        else $error("supply scale write lost");

    power_write_a:
    assert property (cfg_wr && !limits_locked
        |=> core_power_report == $past(avs_writedata[CFG_POWER_REPORT]))
        else $error("power report write lost");

    run_hold_a:
    assert property (!cfg_wr |=> $stable(monitor_run))
        else $error("run bit changed without a write");

    fans_hold_a:
    assert property (!cfg_wr |=> $stable(fans_forced_max))
        else $error("full-speed bit changed without a write");

    ready_low_a:
    assert property (req && avs_waitrequest && hit_cfg && !powered_up
        |=> !avs_readdata[CFG_READY])
        else $error("ready flag shown before power-up");

    local_hold_a:
    assert property (st_r.stat1[ST_LOCAL] && !(commit && avs_read && hit_st1)
        |=> st_r.stat1[ST_LOCAL])
        else $error("flag dropped without a read");

    remote2_latch_a:
    assert property (limit_fault[ST_REMOTE2] |=> st_r.stat1[ST_REMOTE2])
        else $error("remote 2 flag not latched");

    supply_latch_a:
    assert property (limit_fault[ST_SUPPLY] |=> st_r.stat1[ST_SUPPLY])
        else $error("supply flag not latched");

    v5_latch_a:
    assert property (!overtemp_mode && limit_fault[ST_V5_TIMER]
        |=> st_r.stat1[ST_V5_TIMER])
        else $error("5 V flag not latched");

    second_latch_a:
    assert property (secondary_fault[0] |=> st_r.stat2[0])
        else $error("secondary flag not latched");

    second_clear_a:
    assert property (commit && avs_read && hit_st2
        && st_r.rdata[0] && !secondary_fault[0]
        |=> !st_r.stat2[0])
        else $error("secondary flag not cleared by read");

    summary_flag_a:
    assert property (any_secondary_flag == (|st_r.stat2))
        else $error("summary output wrong");

    timer_drop_a:
    assert property (!st_r.pin_sync |=> !st_r.ovt_over)
        else $error("timer overrun kept after pin release");

    idle_wait_a:
    assert property (!req && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without a request");

    readdata_top_a:
    assert property (avs_readdata[31:8] == 24'h000000)
        else $error("unused read data bits set");

endmodule : monitor_config_and_status_regs

// file: monitor_regs_pkg.sv
// Purpose: constants for the monitor configuration and status registers
// Assumes: 32-bit Avalon-MM data, one register per aligned word
// Notes: byte address of a register is four times its index

package monitor_regs_pkg;

    // ------------------------------------------------------------
    // register indices and bus layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_CONFIG = 8'h40;
    localparam logic [7:0] IDX_STATUS1 = 8'h41;
    localparam logic [7:0] IDX_STATUS2 = 8'h42;
    localparam logic [9:0] ADDR_CONFIG = {IDX_CONFIG, 2'h0};
    localparam logic [9:0] ADDR_STATUS1 = {IDX_STATUS1, 2'h0};
    localparam logic [9:0] ADDR_STATUS2 = {IDX_STATUS2, 2'h0};

    // ------------------------------------------------------------
    // configuration bit positions
    // ------------------------------------------------------------
    localparam int CFG_RUN = 0;
    localparam int CFG_LOCK = 1;
    localparam int CFG_READY = 2;
    localparam int CFG_FANS_MAX = 3;
    localparam int CFG_POWER_REPORT = 4;
    localparam int CFG_SPIN_BYPASS = 5;
    localparam int CFG_BUS_TIMEOUT = 6;
    localparam int CFG_SUPPLY_5V = 7;
    // bits frozen by the lock
    localparam logic [7:0] CFG_LOCKABLE_MASK = 8'hD3;

    // ------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------
    localparam int ST_V2P5 = 0;
    localparam int ST_CORE = 1;
    localparam int ST_SUPPLY = 2;
    localparam int ST_V5_TIMER = 3;
    localparam int ST_REMOTE1 = 4;
    localparam int ST_LOCAL = 5;
    localparam int ST_REMOTE2 = 6;
    localparam int ST_ANY_SECONDARY = 7;
    localparam int NUM_FLAGS1 = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CONFIG_RESET = 8'h01;
    localparam logic [7:0] STATUS1_RESET = 8'h00;
    localparam logic [7:0] STATUS2_RESET = 8'h00;

    // ------------------------------------------------------------
    // overtemperature timer tick
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int OVT_TICK_US = 1000;
    localparam int OVT_TICK_CYC = OVT_TICK_US * CLK_MHZ;
    localparam int OVT_CNT_W = 8;

endpackage : monitor_regs_pkg

// file: monitor_host_model.sv
// Purpose: host bus master model for the monitor registers
// Assumes: slave answers by pulling waitrequest low
// Notes: idle address and data lines show inverted last values
`timescale 1ns/1ps

module monitor_host_model
    import monitor_regs_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // avalon-mm master
    output logic [ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
    end

    // ------------------------------------------------------------
    // one transfer, held until waitrequest is seen low
    // ------------------------------------------------------------
    task automatic req(input logic [9:0] a, input logic rd,
                       input logic [7:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= {24'h000000, d};
        // held until the edge that samples waitrequest low
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~{24'h000000, d};
    endtask : req
endmodule : monitor_host_model

// file: monitor_config_and_status_regs_test.sv
// Purpose: self-checking bench for the monitor registers
// Assumes: timer tick shortened to 4 cycles
// Notes: reads queue their expected data, a negedge monitor compares
`timescale 1ns/1ps

module monitor_config_and_status_regs_test
    import monitor_regs_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic powered_up = 1'b0;
    logic [6:0] limit_fault = 7'h00;
    logic [7:0] secondary_fault = 8'h00;
    logic overtemp_mode = 1'b0;
    logic overtemp_pin_n = 1'b1;
    logic [7:0] overtemp_time_limit = 8'h02;
    logic monitor_run, limits_locked, fans_forced_max, core_power_report;
    logic spin_up_pulse_bypass, bus_timeout_select, supply_is_5v;
    logic any_secondary_flag;
    logic [7:0] cfg, f;
    logic [31:0] expq[$];
    int err_total = 0;
    int cmp_count = 0;
    int seed = 28626;
    int i;

    always #4 clk_sys = ~clk_sys;

    monitor_host_model host (.clk_sys(clk_sys), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest));

    monitor_config_and_status_regs #(.TICK_CYCLES(4)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .powered_up(powered_up),
        .limit_fault(limit_fault), .secondary_fault(secondary_fault),
        .overtemp_mode(overtemp_mode), .overtemp_pin_n(overtemp_pin_n),
        .overtemp_time_limit(overtemp_time_limit),
        .monitor_run(monitor_run), .limits_locked(limits_locked),
        .fans_forced_max(fans_forced_max),
        .core_power_report(core_power_report),
        .spin_up_pulse_bypass(spin_up_pulse_bypass),
        .bus_timeout_select(bus_timeout_select),
        .supply_is_5v(supply_is_5v),
        .any_secondary_flag(any_secondary_flag));

    task automatic chk(input logic [31:0] seen, exp, input string m);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, m, seen, exp);
        end
    endtask : chk

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        expq.push_back({24'h000000, e});
        host.req(a, 1'b1, 8'h00);
    endtask : rd

    // model update: locked bits keep their value
    task automatic wr_cfg(input logic [7:0] v);
        logic [7:0] m;
        m = cfg[1] ? 8'h28 : 8'hFB;
        cfg = (cfg & ~m) | (v & m);
        host.req(ADDR_CONFIG, 1'b0, v);
        @(negedge clk_sys);
        chk(32'({supply_is_5v, bus_timeout_select, spin_up_pulse_bypass,
            core_power_report, fans_forced_max, limits_locked, monitor_run}),
            32'({cfg[7:3], cfg[1:0]}), "outs");
        rd(ADDR_CONFIG, cfg | 8'h04);
    endtask : wr_cfg

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // read monitor
    // ------------------------------------------------------------
    always @(negedge clk_sys) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (expq.size() > 0) begin
                chk(avs_readdata, expq.pop_front(), "read");
            end else begin
                chk(avs_readdata, 32'hFFFFFFFF, "stray answer");
            end
        end
    end

    initial begin
        #200000;
        err_total++;
        final_report();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        cfg = 8'h01;
        rd(ADDR_CONFIG, 8'h01);
        powered_up <= 1'b1;
        rd(ADDR_CONFIG, 8'h05);
        rd(ADDR_STATUS1, 8'h00);
        rd(ADDR_STATUS2, 8'h00);
        host.req(ADDR_STATUS1, 1'b0, 8'hFF);
        rd(ADDR_STATUS1, 8'h00);
        rd(10'h3FC, 8'h00);
        done("reset");
        for (i = 0; i < 8; i++) begin
            f = (i < 2) ? (i ? 8'hF9 : 8'h00) : 8'($random(seed));
            wr_cfg(f & 8'hFD);
        end
        done("config");
        for (i = 0; i < 6; i++) begin
            f = i ? 8'($random(seed)) & 8'h7F : 8'h7F;
            limit_fault <= f[6:0];
            repeat (3) @(posedge clk_sys);
            if (i[0]) rd(ADDR_STATUS1, f);
            limit_fault <= 7'h00;
            repeat (2) @(posedge clk_sys);
            rd(ADDR_STATUS1, f);
            rd(ADDR_STATUS1, 8'h00);
        end
        done("status");
        f = 8'($random(seed)) | 8'h01;
        secondary_fault <= f;
        repeat (3) @(posedge clk_sys);
        secondary_fault <= 8'h00;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(32'(any_secondary_flag), 32'h1, "summary");
        rd(ADDR_STATUS1, 8'h80);
        rd(ADDR_STATUS2, f);
        rd(ADDR_STATUS1, 8'h00);
        done("secondary");
        overtemp_mode <= 1'b1;
        overtemp_pin_n <= 1'b0;
        repeat (40) @(posedge clk_sys);
        overtemp_pin_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(ADDR_STATUS1, 8'h08);
        rd(ADDR_STATUS1, 8'h00);
        overtemp_mode <= 1'b0;
        done("timer");
        wr_cfg(8'($random(seed)) | 8'h02);
        for (i = 0; i < 4; i++) wr_cfg(8'($random(seed)));
        done("lock");
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        cfg = 8'h01;
        rd(ADDR_CONFIG, 8'h05);
        done("power cycle");
        repeat (2) @(posedge clk_sys);
        final_report();
    end
endmodule : monitor_config_and_status_regs_test
